// File: pmc_core_model.sv
`timescale 1ns/100ps
module pmc_core_model
  import pmc_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       deep_cmd,
  input  wire logic       sleep_cmd,
  input  wire logic       wake_cmd,
  input  wire pmc_state_t mode,
  output logic            sleep_req,
  output logic            deep_sleep_req,
  output logic            wake_irq
);
  // Requests drop once the mode moves, so a wake never re-enters at once
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sleep_req      <= 1'b0;
      deep_sleep_req <= 1'b0;
      wake_irq       <= 1'b0;
    end
    else
    begin
      sleep_req      <= sleep_cmd && mode == PMC_RUN;
      deep_sleep_req <= deep_cmd && mode == PMC_RUN;
      wake_irq       <= wake_cmd && mode != PMC_RUN;
    end
  end
endmodule : pmc_core_model

// File: pmc_pkg.sv
package pmc_pkg;

  // Register byte offsets
  localparam logic [7:0] PMC_ANALOG_PD_OFS   = 8'h14;
  localparam logic [7:0] PMC_OSC_PD_OFS      = 8'h18;
  localparam logic [7:0] PMC_CLK_CTRL_OFS    = 8'h1c;
  localparam logic [7:0] PMC_WAKE_CTRL_OFS   = 8'h20;
  localparam logic [7:0] PMC_WAKE_STAT_OFS   = 8'h24;
  localparam logic [7:0] PMC_STOP_MASK_OFS   = 8'h28;
  localparam logic [7:0] PMC_STBY_MASK_OFS   = 8'h2c;
  localparam logic [7:0] PMC_MODE_CTRL_OFS   = 8'h30;

  // Writable bit masks (reserved bits read zero)
  localparam logic [31:0] PMC_ANALOG_PD_MSK  = 32'h0000_0ff3;
  localparam logic [31:0] PMC_OSC_PD_MSK     = 32'h0000_003f;
  localparam logic [31:0] PMC_CLK_CTRL_MSK   = 32'h0000_0b73;
  localparam logic [31:0] PMC_WAKE_CTRL_MSK  = 32'h0000_000f;
  localparam logic [31:0] PMC_WAKE_STAT_MSK  = 32'h0000_0013;
  localparam logic [31:0] PMC_STOP_MASK_MSK  = 32'h0000_019f;
  localparam logic [31:0] PMC_STBY_MASK_MSK  = 32'h0000_0fff;
  localparam logic [31:0] PMC_MODE_CTRL_MSK  = 32'h0000_0030;

  // Reset values
  localparam logic [31:0] PMC_ANALOG_PD_RST  = 32'h0000_0f80;
  localparam logic [31:0] PMC_OSC_PD_RST     = 32'h0000_003e;
  localparam logic [31:0] PMC_CLK_CTRL_RST   = 32'h0000_0050;
  localparam logic [31:0] PMC_STOP_MASK_RST  = 32'h0000_001f;
  localparam logic [31:0] PMC_STBY_MASK_RST  = 32'h0000_001f;

  // Field positions: analog power-down
  localparam int PMC_AN_DAC_BIT   = 11;
  localparam int PMC_AN_R2R_BIT   = 10;
  localparam int PMC_AN_ADC_BIT   = 9;
  localparam int PMC_AN_CMP_LSB   = 7;
  localparam int PMC_AN_KEEP_BIT  = 6;
  localparam int PMC_AN_SLX_BIT   = 5;
  localparam int PMC_AN_SLE_BIT   = 4;
  localparam int PMC_AN_ROM_BIT   = 1;
  localparam int PMC_AN_NVM_BIT   = 0;
  // Oscillator power-down
  localparam int PMC_OSC_USB_BIT  = 5;
  localparam int PMC_OSC_EXT_BIT  = 4;
  localparam int PMC_OSC_PLL_BIT  = 3;
  localparam int PMC_OSC_FAST_BIT = 2;
  localparam int PMC_OSC_SLOW_BIT = 1;
  localparam int PMC_OSC_MS_BIT   = 0;
  // Clock control
  localparam int PMC_CK_DBG_BIT   = 11;
  localparam int PMC_CK_WAKE_BIT  = 9;
  localparam int PMC_CK_KEEP_BIT  = 8;
  localparam int PMC_CK_RANGE_LSB = 4;
  localparam int PMC_CK_SEL_LSB   = 0;
  // Wake control
  localparam int PMC_WK_RSTOP_BIT = 3;
  localparam int PMC_WK_RSTBY_BIT = 2;
  localparam int PMC_WK_PIN1_BIT  = 1;
  localparam int PMC_WK_PIN0_BIT  = 0;
  // Status
  localparam int PMC_ST_BOOT_BIT  = 4;
  localparam int PMC_ST_STOP_BIT  = 1;
  localparam int PMC_ST_STBY_BIT  = 0;
  // Mode control
  localparam int PMC_MD_LPDS_BIT  = 5;
  localparam int PMC_MD_STBY_BIT  = 4;

  // Multi-speed range codes and clock sources
  localparam logic [2:0] PMC_RANGE_MIN = 3'h0;
  localparam logic [2:0] PMC_RANGE_MAX = 3'h6;
  localparam logic [2:0] PMC_RANGE_RST = 3'h5;
  localparam logic [1:0] PMC_SRC_MSOSC = 2'h0;
  localparam logic [1:0] PMC_SRC_FAST  = 2'h1;
  localparam logic [1:0] PMC_SRC_EXT   = 2'h2;
  localparam logic [1:0] PMC_SRC_PLL   = 2'h3;

  typedef enum logic [2:0] {
    PMC_RUN,
    PMC_SLEEP,
    PMC_STOP,
    PMC_STBY
  } pmc_state_t;

  typedef struct packed {
    logic [7:0]  addr;
    logic [31:0] wdata;
    logic        wr;
    logic        rd;
  } pmc_bus_req_t;

  typedef struct packed {
    logic       usb_clock_powerdown;
    logic       external_osc_powerdown;
    logic       multiplier_powerdown;
    logic       fast_internal_osc_powerdown;
    logic       slow_internal_osc_powerdown;
    logic       multispeed_osc_powerdown;
  } pmc_osc_pd_t;

  typedef struct packed {
    logic       low_voltage_reset_a_powerdown;
    logic       low_voltage_reset_b_powerdown;
    logic       brownout_powerdown;
    logic       voltage_detector_powerdown;
    logic       core_supply_monitor_powerdown;
    logic       analog_supply_monitor_powerdown;
    logic       bandgap_digital_powerdown;
    logic       rail_amp_powerdown;
    logic       output_converter_powerdown;
    logic       converter_powerdown;
    logic [1:0] comparator_powerdown;
    logic       boot_rom_powerdown;
    logic       nvm_powerdown;
  } pmc_analog_pd_t;

endpackage : pmc_pkg

// File: pmc_power_mode_bank.sv
`timescale 1ns/100ps
module pmc_power_mode_bank
  import pmc_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [31:0] reg_rdata,
  input  wire logic        sleep_req,
  input  wire logic        deep_sleep_req,
  input  wire logic        wake_irq,
  input  wire logic        nvm_prog_busy,
  input  wire logic        bus_access_busy,
  input  wire logic        wake_pin0,
  input  wire logic        wake_pin1,
  input  wire logic        rtc_wake,
  input  wire logic        independent_watchdog_wake,
  output pmc_state_t       mode,
  output pmc_analog_pd_t   analog_pd,
  output pmc_osc_pd_t      osc_pd,
  output logic             debug_clock_gate,
  output logic      [2:0]  msosc_range,
  output logic      [1:0]  sysclk_sel,
  output logic             main_reg_off,
  output logic             lowpower_reset_req,
  output logic             cpu_clock_stop
);

  logic [31:0] an_r, osc_r, ck_r, wk_r, st_r, smk_r, bmk_r, md_r;
  pmc_state_t  state_r, state_nxt;
  logic        nvm_keep_r, nvm_keep_nxt;
  logic        rst_req_r, rst_req_nxt;
  logic [2:0]  pin0_sync_r, pin1_sync_r, rtc_sync_r, wdt_sync_r;
  logic        pin0_q_r, pin1_q_r, rtc_q_r, wdt_q_r;

  function automatic logic [31:0] pmc_masked(input logic [31:0] d, input logic [31:0] m);
    pmc_masked = d & m;
  endfunction : pmc_masked

  // Bus decode
  wire logic wr_an  = reg_wr && reg_addr == PMC_ANALOG_PD_OFS;
  wire logic wr_osc = reg_wr && reg_addr == PMC_OSC_PD_OFS;
  wire logic wr_ck  = reg_wr && reg_addr == PMC_CLK_CTRL_OFS;
  wire logic wr_wk  = reg_wr && reg_addr == PMC_WAKE_CTRL_OFS;
  wire logic wr_st  = reg_wr && reg_addr == PMC_WAKE_STAT_OFS;
  wire logic wr_smk = reg_wr && reg_addr == PMC_STOP_MASK_OFS;
  wire logic wr_bmk = reg_wr && reg_addr == PMC_STBY_MASK_OFS;
  wire logic wr_md  = reg_wr && reg_addr == PMC_MODE_CTRL_OFS;

  // Pin inputs pass three flops; a change counts when stages two and three agree
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin0_sync_r <= 3'h0;
      pin1_sync_r <= 3'h0;
      rtc_sync_r  <= 3'h0;
      wdt_sync_r  <= 3'h0;
      pin0_q_r    <= 1'b0;
      pin1_q_r    <= 1'b0;
      rtc_q_r     <= 1'b0;
      wdt_q_r     <= 1'b0;
    end
    else
    begin
      pin0_sync_r <= {pin0_sync_r[1:0], wake_pin0};
      pin1_sync_r <= {pin1_sync_r[1:0], wake_pin1};
      rtc_sync_r  <= {rtc_sync_r[1:0], rtc_wake};
      wdt_sync_r  <= {wdt_sync_r[1:0], independent_watchdog_wake};
      if (pin0_sync_r[1] == pin0_sync_r[2]) pin0_q_r <= pin0_sync_r[2];
      if (pin1_sync_r[1] == pin1_sync_r[2]) pin1_q_r <= pin1_sync_r[2];
      if (rtc_sync_r[1] == rtc_sync_r[2])   rtc_q_r  <= rtc_sync_r[2];
      if (wdt_sync_r[1] == wdt_sync_r[2])   wdt_q_r  <= wdt_sync_r[2];
    end
  end

  wire logic pin_wake = (pin0_q_r && wk_r[PMC_WK_PIN0_BIT]) ||
                        (pin1_q_r && wk_r[PMC_WK_PIN1_BIT]);
  wire logic stby_wake = pin_wake || rtc_q_r || wdt_q_r;
  wire logic entry_ok  = !nvm_prog_busy && !bus_access_busy && !reg_wr
                         && !reg_rd;
  wire logic want_stby = md_r[PMC_MD_STBY_BIT];
  wire logic stop_rst  = wk_r[PMC_WK_RSTOP_BIT];
  wire logic stby_rst  = wk_r[PMC_WK_RSTBY_BIT];
  wire logic enter_stop = state_r == PMC_RUN && deep_sleep_req && entry_ok
                          && !want_stby && !stop_rst;
  wire logic enter_stby = state_r == PMC_RUN && deep_sleep_req && entry_ok
                          && want_stby && !stby_rst;
  wire logic stop_exit = state_r == PMC_STOP && (wake_irq || wdt_q_r);
  wire logic stby_exit = state_r == PMC_STBY && stby_wake;

  // Mode sequencer
  always_comb
  begin
    state_nxt    = state_r;
    nvm_keep_nxt = nvm_keep_r;
    rst_req_nxt  = 1'b0;
    unique case (state_r)
      PMC_RUN:
      begin
        if (deep_sleep_req && entry_ok)
        begin
          if (want_stby ? stby_rst : stop_rst)
            rst_req_nxt = 1'b1;
          else
            state_nxt = want_stby ? PMC_STBY : PMC_STOP;
        end
        else if (sleep_req)
        begin
          state_nxt = PMC_SLEEP;
          nvm_keep_nxt = an_r[PMC_AN_SLE_BIT];
        end
        else if (wr_an && !reg_wdata[PMC_AN_KEEP_BIT])
          nvm_keep_nxt = 1'b0;
      end
      PMC_SLEEP:
      begin
        if (wake_irq)
        begin
          state_nxt = PMC_RUN;
          nvm_keep_nxt = an_r[PMC_AN_SLX_BIT];
        end
      end
      PMC_STOP:
      begin
        if (stop_exit)
        begin
          state_nxt = PMC_RUN;
          nvm_keep_nxt = an_r[PMC_AN_KEEP_BIT];
        end
      end
      PMC_STBY:
      begin
        // Standby exit always goes through reset of the core
        if (stby_exit)
        begin
          state_nxt = PMC_RUN;
          rst_req_nxt = 1'b1;
          nvm_keep_nxt = 1'b0;
        end
      end
      default: state_nxt = PMC_RUN;
    endcase
  end

  // Register file
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      an_r       <= PMC_ANALOG_PD_RST;
      osc_r      <= PMC_OSC_PD_RST;
      ck_r       <= PMC_CLK_CTRL_RST;
      wk_r       <= 32'h0;
      st_r       <= 32'h0;
      smk_r      <= PMC_STOP_MASK_RST;
      bmk_r      <= PMC_STBY_MASK_RST;
      md_r       <= 32'h0;
      state_r    <= PMC_RUN;
      nvm_keep_r <= 1'b0;
      rst_req_r  <= 1'b0;
    end
    else
    begin
      state_r    <= state_nxt;
      nvm_keep_r <= nvm_keep_nxt;
      rst_req_r  <= rst_req_nxt;
      if (wr_an)  an_r  <= pmc_masked(reg_wdata, PMC_ANALOG_PD_MSK);
      if (wr_osc) osc_r <= pmc_masked(reg_wdata, PMC_OSC_PD_MSK);
      if (wr_wk)  wk_r  <= pmc_masked(reg_wdata, PMC_WAKE_CTRL_MSK);
      if (wr_smk) smk_r <= pmc_masked(reg_wdata, PMC_STOP_MASK_MSK);
      if (wr_bmk) bmk_r <= pmc_masked(reg_wdata, PMC_STBY_MASK_MSK);
      if (wr_md)  md_r  <= pmc_masked(reg_wdata, PMC_MODE_CTRL_MSK);
      // Standby exit restores default clock over any pending write
      if (stby_exit)
      begin
        ck_r[PMC_CK_SEL_LSB +: 2]   <= PMC_SRC_MSOSC;
        ck_r[PMC_CK_RANGE_LSB +: 3] <= PMC_RANGE_RST;
      end
      else if (stop_exit)
        ck_r[PMC_CK_SEL_LSB +: 2] <= ck_r[PMC_CK_WAKE_BIT] ? PMC_SRC_FAST
                                                          : PMC_SRC_MSOSC;
      else if (wr_ck)
        ck_r <= pmc_masked(reg_wdata, PMC_CLK_CTRL_MSK);
      // Set wins over a write-one clear in the same cycle
      if (wr_st)
        st_r[PMC_ST_BOOT_BIT] <= reg_wdata[PMC_ST_BOOT_BIT];
      st_r[PMC_ST_STOP_BIT] <= stop_exit ||
        (st_r[PMC_ST_STOP_BIT] && !(wr_st && reg_wdata[PMC_ST_STOP_BIT]));
      st_r[PMC_ST_STBY_BIT] <= stby_exit ||
        (st_r[PMC_ST_STBY_BIT] && !(wr_st && reg_wdata[PMC_ST_STBY_BIT]));
    end
  end

  // Read data, one cycle after the strobe
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      reg_rdata <= 32'h0;
    else if (reg_rd)
    begin
      unique case (reg_addr)
        PMC_ANALOG_PD_OFS: reg_rdata <= an_r;
        PMC_OSC_PD_OFS:    reg_rdata <= osc_r;
        PMC_CLK_CTRL_OFS:  reg_rdata <= ck_r;
        PMC_WAKE_CTRL_OFS: reg_rdata <= wk_r;
        PMC_WAKE_STAT_OFS: reg_rdata <= st_r;
        PMC_STOP_MASK_OFS: reg_rdata <= smk_r;
        PMC_STBY_MASK_OFS: reg_rdata <= bmk_r;
        PMC_MODE_CTRL_OFS: reg_rdata <= md_r;
        default:           reg_rdata <= 32'h0;
      endcase
    end
    else
      reg_rdata <= 32'h0;
  end

  // Forced power-downs only while in stop or standby
  wire logic in_stop = state_r == PMC_STOP;
  wire logic in_stby = state_r == PMC_STBY;
  wire logic [11:0] force_pd = ({12{in_stop}} & {3'h0, smk_r[8:0]})
                             | ({12{in_stby}} & bmk_r[11:0]);
  wire logic deep = in_stop || in_stby;

  always_comb
  begin
    analog_pd.low_voltage_reset_a_powerdown   = force_pd[8];
    analog_pd.low_voltage_reset_b_powerdown   = force_pd[7];
    analog_pd.brownout_powerdown              = force_pd[10];
    analog_pd.voltage_detector_powerdown      = force_pd[9];
    analog_pd.core_supply_monitor_powerdown   = force_pd[6];
    analog_pd.analog_supply_monitor_powerdown = force_pd[5];
    analog_pd.bandgap_digital_powerdown       = force_pd[11];
    analog_pd.rail_amp_powerdown         = an_r[PMC_AN_R2R_BIT] | force_pd[4];
    analog_pd.output_converter_powerdown = an_r[PMC_AN_DAC_BIT] | force_pd[3];
    analog_pd.converter_powerdown        = an_r[PMC_AN_ADC_BIT] | force_pd[2];
    analog_pd.comparator_powerdown = an_r[PMC_AN_CMP_LSB +: 2] | {2{force_pd[1]}};
    analog_pd.boot_rom_powerdown   = an_r[PMC_AN_ROM_BIT];
    analog_pd.nvm_powerdown = an_r[PMC_AN_NVM_BIT] | nvm_keep_r | deep
                              | (state_r == PMC_SLEEP && nvm_keep_r);
    osc_pd.usb_clock_powerdown         = osc_r[PMC_OSC_USB_BIT] | deep;
    osc_pd.external_osc_powerdown      = osc_r[PMC_OSC_EXT_BIT] | deep;
    osc_pd.multiplier_powerdown        = osc_r[PMC_OSC_PLL_BIT] | deep;
    osc_pd.fast_internal_osc_powerdown = osc_r[PMC_OSC_FAST_BIT] | in_stby
      | (in_stop && !ck_r[PMC_CK_KEEP_BIT]);
    osc_pd.slow_internal_osc_powerdown = osc_r[PMC_OSC_SLOW_BIT] | force_pd[0];
    osc_pd.multispeed_osc_powerdown    = osc_r[PMC_OSC_MS_BIT] | deep;
  end

  assign mode               = state_r;
  assign debug_clock_gate   = ck_r[PMC_CK_DBG_BIT];
  assign msosc_range        = ck_r[PMC_CK_RANGE_LSB +: 3];
  assign sysclk_sel         = ck_r[PMC_CK_SEL_LSB +: 2];
  assign main_reg_off       = md_r[PMC_MD_LPDS_BIT]
                              && (state_r == PMC_SLEEP || in_stop);
  assign lowpower_reset_req = rst_req_r;
  assign cpu_clock_stop     = state_r != PMC_RUN;

  a_stop_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    stop_exit |=> st_r[PMC_ST_STOP_BIT]) else $error("stop flag not set");
  a_stby_flag_set: assert property (@(posedge clk) disable iff (!rst_n)
    stby_exit |=> st_r[PMC_ST_STBY_BIT] && lowpower_reset_req)
    else $error("standby wake flag or reset missing");
  a_stop_rst_req: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == PMC_RUN && deep_sleep_req && entry_ok && !want_stby && stop_rst)
    |=> lowpower_reset_req && mode == PMC_RUN) else $error("stop reset missing");
  a_stby_rst_req: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == PMC_RUN && deep_sleep_req && entry_ok && want_stby && stby_rst)
    |=> lowpower_reset_req && mode == PMC_RUN) else $error("standby reset missing");
  a_entry_waits: assert property (@(posedge clk) disable iff (!rst_n)
    (state_r == PMC_RUN && nvm_prog_busy) |=> !(mode inside {PMC_STOP, PMC_STBY}))
    else $error("entry during flash busy");
  a_stby_select: assert property (@(posedge clk) disable iff (!rst_n)
    enter_stby |=> mode == PMC_STBY) else $error("standby not entered");
  a_stop_select: assert property (@(posedge clk) disable iff (!rst_n)
    enter_stop |=> mode == PMC_STOP) else $error("stop not entered");
  a_stby_clk_def: assert property (@(posedge clk) disable iff (!rst_n)
    stby_exit |=> sysclk_sel == PMC_SRC_MSOSC && msosc_range == PMC_RANGE_RST)
    else $error("standby exit clock wrong");
  a_stop_wake_clk: assert property (@(posedge clk) disable iff (!rst_n)
    (stop_exit && ck_r[PMC_CK_WAKE_BIT]) |=> sysclk_sel == PMC_SRC_FAST)
    else $error("stop wake clock wrong");
  a_mask_release: assert property (@(posedge clk) disable iff (!rst_n)
    (mode == PMC_RUN) |-> analog_pd.brownout_powerdown == 1'b0)
    else $error("mask force outside low power");

endmodule : pmc_power_mode_bank

// File: tb.sv
`timescale 1ns/100ps
module tb;
  import pmc_pkg::*;
  logic           clk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0;
  logic [7:0]     reg_addr = 0;
  logic [31:0]    reg_wdata = 0, reg_rdata, d, v;
  logic           sleep_req, deep_sleep_req, wake_irq, nvm_prog_busy = 0;
  logic           wake_pin0 = 0, wake_pin1 = 0, deep_cmd = 0, wake_cmd = 0;
  logic           rtc_wake = 0, wdt_wake = 0, bus_busy = 0, sleep_cmd = 0;
  pmc_state_t     mode;
  pmc_analog_pd_t analog_pd;
  pmc_osc_pd_t    osc_pd;
  logic           debug_clock_gate, main_reg_off, lowpower_reset_req, cpu_clock_stop;
  logic [2:0]     msosc_range;
  logic [1:0]     sysclk_sel;
  int             n_fail = 0, n_checks = 0;
  logic [7:0]     ofs [8] = '{8'h14, 8'h18, 8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30};
  logic [31:0]    rst [8] = '{32'hf80, 32'h3e, 32'h50, 0, 0, 32'h1f, 32'h1f, 0};
  logic [31:0]    msk [8] = '{PMC_ANALOG_PD_MSK, PMC_OSC_PD_MSK, PMC_CLK_CTRL_MSK,
                    PMC_WAKE_CTRL_MSK, PMC_WAKE_STAT_MSK, PMC_STOP_MASK_MSK,
                    PMC_STBY_MASK_MSK, PMC_MODE_CTRL_MSK};
  always #12.5 clk = ~clk;
  pmc_power_mode_bank u_dut (.clk(clk), .rst_n(rst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .sleep_req(sleep_req), .deep_sleep_req(deep_sleep_req), .wake_irq(wake_irq),
    .nvm_prog_busy(nvm_prog_busy), .bus_access_busy(bus_busy), .wake_pin0(wake_pin0),
    .wake_pin1(wake_pin1), .rtc_wake(rtc_wake), .independent_watchdog_wake(wdt_wake),
    .mode(mode), .analog_pd(analog_pd), .osc_pd(osc_pd),
    .debug_clock_gate(debug_clock_gate), .msosc_range(msosc_range),
    .sysclk_sel(sysclk_sel), .main_reg_off(main_reg_off),
    .lowpower_reset_req(lowpower_reset_req), .cpu_clock_stop(cpu_clock_stop));
  pmc_core_model u_core (.clk(clk), .rst_n(rst_n), .deep_cmd(deep_cmd),
    .sleep_cmd(sleep_cmd), .wake_cmd(wake_cmd), .mode(mode), .sleep_req(sleep_req),
    .deep_sleep_req(deep_sleep_req), .wake_irq(wake_irq));
  function automatic logic [31:0] f_exp(input int i, input logic [31:0] w);
    return w & msk[i];
  endfunction : f_exp
  task automatic summarize;
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask : summarize
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e)
    begin
      n_fail++;
      $display("mismatch %s expected %h seen %h", nm, e, s);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= w;
    reg_wr <= 1;
    @(posedge clk);
    reg_wr <= 0;
    #1;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] r);
    @(posedge clk);
    reg_addr <= a;
    reg_rd <= 1;
    @(posedge clk);
    reg_rd <= 0;
    #1 r = reg_rdata;
  endtask : rd
  // Bounded waits; running out counts as a mismatch and closes the run
  task automatic wait_mode(input pmc_state_t m);
    int k;
    for (k = 0; k < 50 && mode !== m; k++)
      @(posedge clk) #1;
    if (mode !== m)
    begin
      chk("mode wait", 32'(mode), 32'(m));
      summarize();
    end
  endtask : wait_mode
  task automatic wait_pulse;
    int k;
    for (k = 0; k < 50 && lowpower_reset_req !== 1'b1; k++)
      @(posedge clk) #1;
    if (lowpower_reset_req !== 1'b1)
    begin
      chk("reset pulse wait", 0, 1);
      summarize();
    end
  endtask : wait_pulse
  initial
  begin
    void'($urandom(32'h2a9c));
    repeat (2) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 8; i++)
    begin
      rd(ofs[i], d);
      chk("reset value", d, rst[i]);
    end
    rd(8'h34, d);
    chk("unmapped", d, 0);
    repeat (3)
      for (int i = 0; i < 8; i++)
        if (i != 4)
        begin
          v = $urandom;
          wr(ofs[i], v);
          rd(ofs[i], d);
          chk("readback", d, f_exp(i, v));
        end
    for (int k = 0; k < 4; k++)
    begin
      v = ($urandom & 32'hffff_fffc) | k;
      wr(8'h1c, v);
      chk("clock select", 32'(sysclk_sel), 32'(v[1:0]));
      chk("range", 32'(msosc_range), 32'(v[6:4]));
      chk("debug gate", 32'(debug_clock_gate), 32'(v[11]));
      wr(8'h18, v);
      chk("osc pd", 32'(osc_pd), 32'(v[5:0]));
      wr(8'h14, v & 32'h0f80);
      chk("comparator_powerdown", 32'(analog_pd.comparator_powerdown), 32'(v[8:7]));
      chk("converter_powerdown", 32'(analog_pd.converter_powerdown), 32'(v[9]));
    end
    wr(8'h14, 32'h40);
    wr(8'h18, 0);
    wr(8'h1c, 32'h300);
    wr(8'h20, 0);
    wr(8'h28, 32'h1f);
    wr(8'h30, 32'h20);
    wr(8'h24, 3);
    nvm_prog_busy <= 1;
    bus_busy <= 1;
    deep_cmd <= 1;
    repeat (6) @(posedge clk);
    #1 chk("busy defers", 32'(mode), 32'(PMC_RUN));
    nvm_prog_busy <= 0;
    repeat (4) @(posedge clk);
    #1 chk("bus access defers", 32'(mode), 32'(PMC_RUN));
    bus_busy <= 0;
    wait_mode(PMC_STOP);
    deep_cmd <= 0;
    chk("stop forced", 32'(analog_pd[5:2]), 4'hf);
    chk("stop slow osc", 32'(osc_pd.slow_internal_osc_powerdown), 1);
    chk("fast osc kept", 32'(osc_pd.fast_internal_osc_powerdown), 0);
    chk("regulator off", 32'(main_reg_off), 1);
    chk("cpu clock", 32'(cpu_clock_stop), 1);
    wake_cmd <= 1;
    wait_mode(PMC_RUN);
    wake_cmd <= 0;
    chk("stop wake clock", 32'(sysclk_sel), 32'(PMC_SRC_FAST));
    chk("forced released", 32'(analog_pd[5:2]), 0);
    chk("flash kept off", 32'(analog_pd.nvm_powerdown), 1);
    rd(8'h24, d);
    chk("stop flag", d, 2);
    wr(8'h24, 0);
    rd(8'h24, d);
    chk("flag write zero", d, 2);
    wr(8'h24, 2);
    rd(8'h24, d);
    chk("flag cleared", d, 0);
    // Entry bit alone, then exit bit alone; bit 6 low also drops the kept flash
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h14, k ? 32'h20 : 32'h10);
      chk("flash latch clear", 32'(analog_pd.nvm_powerdown), 0);
      sleep_cmd <= 1;
      wait_mode(PMC_SLEEP);
      sleep_cmd <= 0;
      chk("sleep entry flash", 32'(analog_pd.nvm_powerdown), 32'(!k));
      chk("sleep regulator", 32'(main_reg_off), 1);
      wake_cmd <= 1;
      wait_mode(PMC_RUN);
      wake_cmd <= 0;
      chk("sleep exit flash", 32'(analog_pd.nvm_powerdown), 32'(k));
    end
    for (int k = 0; k < 2; k++)
    begin
      wr(8'h20, k ? 32'h4 : 32'h8);
      wr(8'h30, k ? 32'h10 : 32'h0);
      deep_cmd <= 1;
      wait_pulse();
      deep_cmd <= 0;
      chk("reset not entry", 32'(mode), 32'(PMC_RUN));
      repeat (4) @(posedge clk);
    end
    wr(8'h20, 1);
    wr(8'h2c, 32'hfff);
    wr(8'h30, 32'h10);
    wr(8'h1c, 32'h3);
    deep_cmd <= 1;
    wait_mode(PMC_STBY);
    deep_cmd <= 0;
    chk("standby forced", 32'(analog_pd[13:2]), 12'hfff);
    wake_pin1 <= 1;
    repeat (8) @(posedge clk);
    #1 chk("disabled pin", 32'(mode), 32'(PMC_STBY));
    wake_pin0 <= 1;
    wait_pulse();
    wake_pin0 <= 0;
    wake_pin1 <= 0;
    repeat (3) @(posedge clk);
    #1 chk("exit clock", 32'(sysclk_sel), 32'(PMC_SRC_MSOSC));
    chk("exit range", 32'(msosc_range), 32'(PMC_RANGE_RST));
    rd(8'h24, d);
    chk("standby flag", d & 1, 1);
    wr(8'h24, 1);
    rd(8'h24, d);
    chk("standby cleared", d & 1, 0);
    // Timer and watchdog wakes; the settle time lets the synchronisers drain
    for (int k = 0; k < 2; k++)
    begin
      deep_cmd <= 1;
      wait_mode(PMC_STBY);
      deep_cmd <= 0;
      if (k)
        wdt_wake <= 1;
      else
        rtc_wake <= 1;
      wait_pulse();
      rtc_wake <= 0;
      wdt_wake <= 0;
      repeat (8) @(posedge clk);
      #1 chk("timer wake", 32'(mode), 32'(PMC_RUN));
    end
    summarize();
  end
endmodule : tb
